// ==== hw/sar_conv_pkg.sv ====
// Constants shared by the converter control and serial readout block
`default_nettype none

package sar_conv_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned ACQ_START_NS = 527;
    localparam int unsigned CONV_TIME_NS = 3000;
    // Acquire start is a least time: round up
    localparam int unsigned ACQ_START_CYC = (ACQ_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Conversion time is a longest time: round down
    localparam int unsigned CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Data layout and reset values
    // ------------------------------------------------------------
    localparam int unsigned RESULT_BITS = 16;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // Power states of the converter
    typedef enum logic [1:0]
    {
        PWR_NAP = 2'b00,
        PWR_CONVERT = 2'b01,
        PWR_SLEEP = 2'b10
    } power_state_t;

endpackage : sar_conv_pkg

`default_nettype wire

// ==== hw/sar_result_shifter.sv ====
// Serial shift register on the link clock: result load and chain shifting
`default_nettype none

module sar_result_shifter #(
    parameter int unsigned WIDTH = 16
) (
    // Link clock
    input wire logic i_sck,
    // Load request level from the system domain, held until SCK is seen
    input wire logic i_load_toggle,
    input wire logic [WIDTH-1:0] i_load_data,
    // Serial input and chain select, both already stable on this clock
    input wire logic i_serial_in,
    input wire logic i_chain,
    // Serial output bit, changes after each SCK rising edge
    output logic o_bit,
    // Toggles once per SCK rising edge seen
    output logic o_edge_toggle
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 2)
    begin : g_bad_width
        $error("sar_result_shifter: WIDTH must be at least 2");
    end

    logic fill_bit;
    logic [WIDTH-1:0] shift;
    logic [WIDTH-1:0] next_shift;

    // Chain mode pulls the upstream bit in at the bottom; normal fills zero.
    // SCK stands still between frames, so no synchroniser can run here: the
    // load level is read directly. It has stood for several system cycles before
    // the first rise, as long as the host reads after the conversion ends.
    // The top bit is shown by the system side, so the first rise loads and
    // shifts in one step.
    always_comb
    begin
        fill_bit = i_chain ? i_serial_in : 1'b0;
        next_shift = i_load_toggle ? {i_load_data[WIDTH-2:0], fill_bit}
                                   : {shift[WIDTH-2:0], fill_bit};
    end

    // Each SCK rise shifts one bit, most significant first
    always_ff @(posedge i_sck)
    begin
        o_edge_toggle <= ~o_edge_toggle;
        shift <= next_shift;
    end

    assign o_bit = shift[WIDTH-1];

endmodule : sar_result_shifter

`default_nettype wire

// ==== hw/sar_adc_control.sv ====
// Conversion control, nap and sleep handling and serial readout of the converter
`default_nettype none

module sar_adc_control #(
    parameter int unsigned RESULT_WIDTH = sar_conv_pkg::RESULT_BITS
) (
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Link clock
    input wire logic i_sck,
    // Host pins
    input wire logic i_conversion_start_pin,
    input wire logic i_read_enable_or_serial_in,
    input wire logic i_chain_select,
    // Result from the converter core
    input wire logic [RESULT_WIDTH-1:0] i_core_result,
    // Status pins
    output logic o_busy,
    output logic o_core_power,
    output logic o_acquire,
    output logic o_sleep,
    // Serial data pin
    output logic o_sdo,
    output logic o_sdo_oe
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (RESULT_WIDTH != sar_conv_pkg::RESULT_BITS)
    begin : g_bad_width
        $error("sar_adc_control: RESULT_WIDTH must match the 16-bit core");
    end

    localparam logic [7:0] CONV_LAST = 8'(sar_conv_pkg::CONV_CYC - 1);
    localparam logic [7:0] ACQ_AT = 8'(sar_conv_pkg::ACQ_START_CYC);

    sar_conv_pkg::power_state_t state;
    logic [2:0] cnv_sync;
    logic [1:0] chain_sync;
    logic [2:0] rden_sync;
    logic [2:0] sck_edge_sync;
    logic [7:0] conv_cnt;
    logic cnv_rise;
    logic cnv_fall;
    logic sck_seen;
    logic [1:0] toggle_cnt;
    logic sleep_pending;
    logic [RESULT_WIDTH-1:0] result;
    logic top_hold;
    logic shift_bit;
    logic [1:0] bit_sync;
    logic sdo_from_link;
    logic rden_low_fresh;

    // ------------------------------------------------------------
    // Input synchronisers on the system clock
    // ------------------------------------------------------------
    // Stage 0 is read only by stage 1; edges are found between 1 and 2
    always_ff @(posedge i_clk_sys)
    begin
        cnv_sync <= {cnv_sync[1:0], i_conversion_start_pin};
        chain_sync <= {chain_sync[0], i_chain_select};
        rden_sync <= {rden_sync[1:0], i_read_enable_or_serial_in};
        // SCK is sampled as a pin; its high phase spans several system cycles
        sck_edge_sync <= {sck_edge_sync[1:0], i_sck};
    end

    assign cnv_rise = cnv_sync[1] & ~cnv_sync[2];
    assign cnv_fall = ~cnv_sync[1] & cnv_sync[2];
    assign sck_seen = sck_edge_sync[1] & ~sck_edge_sync[2];
    assign rden_low_fresh = ~rden_sync[1] & rden_sync[2];

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    // A running conversion ignores new CONVERSION_START_PIN rises; host must avoid them
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            state <= sar_conv_pkg::PWR_NAP;
            conv_cnt <= 8'h00;
        end
        else
        begin
            unique case (state)
                sar_conv_pkg::PWR_NAP:
                begin
                    if (cnv_rise)
                    begin
                        state <= sar_conv_pkg::PWR_CONVERT;
                        conv_cnt <= 8'h00;
                    end
                end
                sar_conv_pkg::PWR_CONVERT:
                begin
                    conv_cnt <= conv_cnt + 8'h01;
                    if (conv_cnt == CONV_LAST)
                    begin
                        state <= sleep_pending ? sar_conv_pkg::PWR_SLEEP
                                               : sar_conv_pkg::PWR_NAP;
                    end
                end
                sar_conv_pkg::PWR_SLEEP:
                begin
                    if (sck_seen)
                    begin
                        state <= sar_conv_pkg::PWR_NAP;
                    end
                end
                default:
                begin
                    state <= sar_conv_pkg::PWR_NAP;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sleep request: CONVERSION_START_PIN toggled twice with no SCK rise in between
    // ------------------------------------------------------------
    // Counts CONVERSION_START_PIN edges; an SCK rise restarts the count
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            toggle_cnt <= 2'b00;
            sleep_pending <= 1'b0;
        end
        else if (state == sar_conv_pkg::PWR_SLEEP)
        begin
            toggle_cnt <= 2'b00;
            sleep_pending <= 1'b0;
        end
        else if (sck_seen)
        begin
            toggle_cnt <= 2'b00;
            sleep_pending <= 1'b0;
        end
        else if (cnv_rise | cnv_fall)
        begin
            // A full toggle is a rise and a fall; two toggles make four edges
            if (toggle_cnt == 2'b11)
            begin
                sleep_pending <= 1'b1;
            end
            toggle_cnt <= toggle_cnt + 2'b01;
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    // Busy, core power and acquire window follow the conversion counter
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_busy <= 1'b0;
            o_core_power <= 1'b0;
            o_acquire <= 1'b1;
            o_sleep <= 1'b0;
        end
        else
        begin
            o_busy <= (state == sar_conv_pkg::PWR_CONVERT) && (conv_cnt != CONV_LAST);
            o_core_power <= (state == sar_conv_pkg::PWR_CONVERT)
                            && (conv_cnt != CONV_LAST);
            // Sampling ends at conversion start and resumes 27 cycles (540 ns) later
            o_acquire <= (state != sar_conv_pkg::PWR_CONVERT) || (conv_cnt >= ACQ_AT);
            // Sleep shows at the busy falling edge, and ends as SCK is seen
            o_sleep <= ((state == sar_conv_pkg::PWR_SLEEP) && !sck_seen)
                       || ((state == sar_conv_pkg::PWR_CONVERT)
                           && (conv_cnt == CONV_LAST) && sleep_pending);
        end
    end

    // ------------------------------------------------------------
    // Result capture and hand-over to the link domain
    // ------------------------------------------------------------
    // Load on busy falling edge, and again when read enable drops.
    // While the load stands, SDO shows the top bit from this domain, since
    // the link clock is stopped; the first SCK rise seen ends the hold.
    // A load and an SCK rise in one cycle: the load wins.
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            result <= sar_conv_pkg::RESULT_RESET;
            top_hold <= 1'b0;
            o_sdo <= 1'b0;
        end
        else if ((state == sar_conv_pkg::PWR_CONVERT) && (conv_cnt == CONV_LAST))
        begin
            result <= i_core_result;
            top_hold <= 1'b1;
            o_sdo <= i_core_result[RESULT_WIDTH-1];
        end
        else if (rden_low_fresh && !chain_sync[1])
        begin
            top_hold <= 1'b1;
            o_sdo <= result[RESULT_WIDTH-1];
        end
        else
        begin
            if (sck_seen)
            begin
                top_hold <= 1'b0;
            end
            // Later bits come back from the shifter, a few cycles after SCK
            o_sdo <= (top_hold && !sck_seen) ? result[RESULT_WIDTH-1] : bit_sync[1];
        end
    end

    // ------------------------------------------------------------
    // Link-domain serial logic
    // ------------------------------------------------------------
    // Chain data comes from an upstream device on this same SCK, so it is
    // taken at the rise without a synchroniser. The mode pin is static and
    // settles in the system domain long before any frame; a link-side
    // synchroniser would need SCK edges that a stopped clock never gives.
    sar_result_shifter #(
        .WIDTH(RESULT_WIDTH)
    ) u_shifter (
        .i_sck(i_sck),
        .i_load_toggle(top_hold),
        .i_load_data(result),
        .i_serial_in(i_read_enable_or_serial_in),
        .i_chain(chain_sync[1]),
        .o_bit(shift_bit),
        .o_edge_toggle()
    );

    assign sdo_from_link = shift_bit;

    // ------------------------------------------------------------
    // SDO pin driver
    // ------------------------------------------------------------
    // Shifter bit crosses through two system flops; SCK is eight times slower
    always_ff @(posedge i_clk_sys)
    begin
        bit_sync <= {bit_sync[0], sdo_from_link};
    end

    // Enable follows mode and read enable
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_sdo_oe <= 1'b0;
        end
        else
        begin
            o_sdo_oe <= chain_sync[1] | ~rden_sync[1];
        end
    end

endmodule : sar_adc_control

`default_nettype wire

// ==== tb/sar_adc_checker.sv ====
// Concurrent checks on the converter control ports
`default_nettype none
module sar_adc_checker (
    // Clocks and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_sck,
    // Host pins
    input wire logic i_read_enable_or_serial_in,
    input wire logic i_chain_select,
    input wire logic i_conversion_start_pin,
    // Status and serial pins
    input wire logic o_busy,
    input wire logic o_core_power,
    input wire logic o_acquire,
    input wire logic o_sleep,
    input wire logic o_sdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    int busy_len;
    int acq_len;
    // ----------------------------------------
    // Lengths of busy high and acquire low
    // ----------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        busy_len <= o_busy ? busy_len + 1 : 0;
        acq_len <= o_acquire ? 0 : acq_len + 1;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_busy_starts:
        assert property ($rose(i_conversion_start_pin) && !o_busy && !o_sleep |-> ##[2:5] o_busy)
        else $error("busy did not follow a start");
    a_busy_length:
        assert property ($fell(o_busy) |-> busy_len == sar_conv_pkg::CONV_CYC - 1)
        else $error("conversion length wrong");
    a_acq_drop:
        assert property ($rose(o_busy) |-> !o_acquire) else $error("acquire not ended at start");
    a_acq_length:
        assert property ($rose(o_acquire) |-> acq_len == sar_conv_pkg::ACQ_START_CYC)
        else $error("acquire resumed at wrong time");
    a_core_on:
        assert property (o_busy |-> o_core_power) else $error("core off while busy");
    a_core_nap:
        assert property ($fell(o_busy) |-> !o_core_power) else $error("core on after conversion");
    a_sleep_entry:
        assert property ($rose(o_sleep) |-> $fell(o_busy)) else $error("sleep off busy fall");
    a_sleep_wake:
        assert property (o_sleep && $rose(i_sck) |-> ##[1:10] !o_sleep) else $error("no wake");
    a_sdo_release:
        assert property ((!i_chain_select && i_read_enable_or_serial_in)[*4] |-> !o_sdo_oe)
        else $error("SDO driven while disabled");
    a_sdo_drive:
        assert property ((!o_sleep && (i_chain_select || !i_read_enable_or_serial_in))[*4]
            |-> o_sdo_oe) else $error("SDO not driven");
    c_conv: cover property ($fell(o_busy));
    c_sleep: cover property ($rose(o_sleep));
    c_chain: cover property (i_chain_select && o_sdo_oe);
endmodule : sar_adc_checker
bind sar_adc_control sar_adc_checker u_sar_adc_checker (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_sck(i_sck), .i_read_enable_or_serial_in(i_read_enable_or_serial_in),
    .i_chain_select(i_chain_select), .i_conversion_start_pin(i_conversion_start_pin),
    .o_busy(o_busy), .o_core_power(o_core_power), .o_acquire(o_acquire),
    .o_sleep(o_sleep), .o_sdo_oe(o_sdo_oe));
`default_nettype wire

// ==== tb/sar_host_model.sv ====
// Host model: link clock in frames, upstream chain data, SDO capture
`default_nettype none
module sar_host_model (
    // Serial pins
    output logic o_sck,
    output logic o_sdi,
    input wire logic i_sdo,
    input wire logic i_sdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] word = 32'h0;
    logic line = 1'b0;
    initial o_sck = 1'b0;
    initial o_sdi = 1'b0;
    // No pull on SDO: a released line shows the inverse of its last level
    always @(i_sdo or i_sdo_oe) line = i_sdo_oe ? i_sdo : ~line;
    // Clock stands low between frames; each bit is taken just before a rise
    task automatic frame(input int n, input logic [15:0] din);
        #37;
        for (int i = 0; i < n; i++)
        begin
            o_sdi = din[15 - (i % 16)];
            #80;
            word = {word[30:0], line};
            o_sck = 1'b1;
            #80;
            o_sck = 1'b0;
        end
    endtask : frame
endmodule : sar_host_model
`default_nettype wire

// ==== tb/sar_adc_control_tb_top.sv ====
// Self-checking bench for the converter control block
`default_nettype none
module sar_adc_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE_CYC = 50; // Wake delay, plain default
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic conversion_start_pin = 1'b0;
    logic ren = 1'b1;
    logic chain = 1'b0;
    logic [15:0] res = 16'h0000;
    logic [15:0] din;
    logic sck, sdi, busy, core_power, acquire, sleep, sdo, sdo_oe;
    int err_count = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    sar_adc_control u_sar_adc_control (.i_clk_sys(clk), .i_reset(reset), .i_sck(sck),
        .i_conversion_start_pin(conversion_start_pin), .i_read_enable_or_serial_in(chain ? sdi : ren),
        .i_chain_select(chain), .i_core_result(res), .o_busy(busy), .o_core_power(core_power),
        .o_acquire(acquire), .o_sleep(sleep), .o_sdo(sdo), .o_sdo_oe(sdo_oe));
    sar_host_model u_sar_host_model (.o_sck(sck), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    // Bounded wait for busy to reach a level, counting cycles
    task automatic wait_busy(input logic lvl, output int n);
        n = 0;
        while (busy !== lvl)
        begin
            tick(1);
            n++;
            if (n > 400)
            begin
                chk("busy wait", 32'h1, 32'h0);
                results();
            end
        end
    endtask : wait_busy
    // Start pulse of hi cycles; the fall stays within 40 ns of the start
    task automatic convert(input int hi);
        int n;
        tick(1);
        conversion_start_pin = 1'b1;
        tick(hi);
        conversion_start_pin = 1'b0;
        wait_busy(1'b1, n);
        chk("core power", 32'h1, 32'(core_power));
        chk("acquire", 32'h0, 32'(acquire));
        wait_busy(1'b0, n);
        chk("busy cycles", sar_conv_pkg::CONV_CYC - 1, 32'(n));
        chk("nap power", 32'h0, 32'(core_power));
        if (!chain && !ren)
            chk("top bit", 32'(res[15]), 32'(sdo));
    endtask : convert
    // Read one result after the conversion, while napping
    task automatic rd;
        u_sar_host_model.frame(16, 16'h0000);
        chk("word", 32'(res), 32'(u_sar_host_model.word[15:0]));
    endtask : rd
    initial
    begin
        void'($urandom(71));
        tick(4);
        reset = 1'b0;
        chk("reset outs", 32'h4, 32'({busy, core_power, acquire, sleep, sdo_oe}));
        tick(10000);
        ren = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            res = (i == 0) ? 16'hffff : (i == 1) ? 16'h0001 : 16'($urandom);
            convert(1 + i % 2);
            chk("no sleep", 32'h0, 32'(sleep));
            rd();
        end
        $display("test single done");
        ren = 1'b1;
        tick(4);
        chk("oe off", 32'h0, 32'(sdo_oe));
        res = 16'($urandom);
        convert(2);
        ren = 1'b0;
        tick(4);
        chk("oe on", 32'h1, 32'(sdo_oe));
        chk("shared top", 32'(res[15]), 32'(sdo));
        rd();
        $display("test shared done");
        // Two start toggles after the last read, no SCK: the second sleeps
        convert(1);
        convert(1);
        chk("sleep", 32'h1, 32'(sleep));
        u_sar_host_model.frame(1, 16'h0000);
        tick(10);
        chk("wake", 32'h0, 32'(sleep));
        tick(WAKE_CYC);
        $display("test sleep done");
        chain = 1'b1;
        tick(4);
        chk("chain oe", 32'h1, 32'(sdo_oe));
        res = 16'($urandom);
        din = 16'($urandom);
        convert(2);
        u_sar_host_model.frame(32, din);
        chk("chain", {res, din}, u_sar_host_model.word);
        $display("test chain done");
        results();
    end
endmodule : sar_adc_control_tb_top
`default_nettype wire
